// file: verilog/sult_loop_test.sv
`include "sult_params.svh"
// Summary of operation
// - Isolate drum, inhibit burst counters, clear alarms first
// - Suppress right word reset during test
// - Start fills all addresses; manual steps singly
// - Flag bits gained or lost in readout
// - Load test register serially per step
// - G/G count 18 sets phase to B
// - Next count 18 returns phase to A
// - Slot flags set auto, clear manual
// - Manual mode writes then reads each address
// - G/G count 18 triggers parallel return
// - Zero test; halt on error if enabled
// - Good result repeats until end pressed
// - G/A stores word per column, 12
// - G/A readout to one or two shifters
// - G/A count 15 toggles decoding phase
// - Dual channel shifts two words together
// - G/A shift on each non-sync pulse
// - G/A pulse at count 17 starts return
// - G/A zero test on gated timing pulse
// - Seventeen stages returned bit for bit
// - G/A parity switch sets buffer parity bit
module sult_loop_test #(
  parameter int WORD_BITS = `SULT_WORD_BITS,
  parameter logic [3:0] NUM_ADDRS = `SULT_GG_ADDRS
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Operator controls.
  input wire logic i_unit_test,
  input wire logic i_start_cycle,
  input wire logic i_end_test,
  input wire logic i_ground_air,
  input wire logic i_manual_step,
  input wire logic i_step,
  input wire logic i_dual_channel,
  input wire logic i_chan2_select,
  input wire logic i_halt_on_error,
  input wire logic i_parity_switch,
  input wire logic [WORD_BITS-1:0] i_test_word,
  // Machine timing.
  input wire logic i_shift_timing_pulse,
  input wire logic i_sync,
  input wire logic i_phase_toggle_pulse,
  input wire logic i_zero_test_timing_pulse,
  input wire logic i_parity_set_timing_pulse,
  input wire logic [4:0] i_bit_count,
  // Data returned from the storage arrays.
  input wire logic i_test_data,
  input wire logic i_test_data_ch2,
  input wire logic i_bit_count_error,
  // Storage and control outputs.
  output logic o_isolate_drum,
  output logic o_inhibit_burst,
  output logic o_clear_alarms,
  output logic o_inhibit_right_reset,
  output logic o_write_en,
  output logic [3:0] o_write_addr,
  output logic o_read_en,
  output logic o_phase,
  output logic o_message_slot_register,
  output logic [1:0] o_osr_load,
  // Buffer register and status.
  output logic [WORD_BITS-1:0] o_output_buffer_register,
  output logic o_error,
  output logic o_halted,
  output logic o_active
);
  sult_pkg::sult_state_t state, next_state;
  logic [WORD_BITS-1:0] tsr, next_tsr, obr, next_obr;
  logic [3:0] addr, next_addr;
  logic phase, next_phase, slots, next_slots, err, next_err;
  logic xfer, next_xfer, zchk, next_zchk, par, next_par;
  logic [1:0] output_shift_register, next_osr;
  logic wr, next_wr, rd, next_rd;
  logic last_count, xfer_pulse, bit_in;
  logic armed, next_armed;
  logic [WORD_BITS-1:0] ret_word;

  // Each stage returns to the buffer bit it came from.
  for (genvar b = 0; b < WORD_BITS; b++) begin : g_return
    assign ret_word[b] = obr[b] ^ tsr[b];
  end

  // G/A word comes on the selected channel line; dual channel does not change which line feeds it.
  assign bit_in = (i_ground_air && i_chan2_select) ? i_test_data_ch2
                                                   : i_test_data;
  assign last_count = i_ground_air ?
      (i_bit_count == `SULT_GA_LAST_COUNT) :
      (i_bit_count == `SULT_GG_LAST_COUNT);
  assign xfer_pulse = i_ground_air ?
      (i_shift_timing_pulse && !i_sync &&
       i_bit_count == `SULT_GA_XFER_COUNT) :
      (i_phase_toggle_pulse &&
       i_bit_count == `SULT_GG_LAST_COUNT);

  always_comb begin
    next_state = state;
    next_tsr = tsr;
    next_obr = obr;
    next_addr = addr;
    next_phase = phase;
    next_slots = slots;
    next_err = err;
    next_xfer = 1'b0;
    next_zchk = zchk;
    next_par = 1'b0;
    next_osr = 2'h0;
    next_wr = 1'b0;
    next_rd = 1'b0;
    next_armed = armed;
    unique case (state)
      sult_pkg::ST_IDLE: begin
        next_obr = i_test_word;
        next_err = 1'b0;
        next_phase = 1'b0;
        if (i_unit_test && i_start_cycle) begin
          next_state = sult_pkg::ST_FILL;
          next_addr = 4'h0;
          next_slots = 1'b0;
        end
      end
      sult_pkg::ST_FILL: begin
        next_armed = 1'b0;
        // Manual mode writes one address then reads it back.
        if (!i_manual_step || i_step) begin
          next_wr = 1'b1;
          if (i_manual_step) begin
            next_state = sult_pkg::ST_READ;
          end else if (addr == NUM_ADDRS - 4'h1) begin
            next_state = sult_pkg::ST_READ;
            next_slots = 1'b1;
          end else begin
            next_addr = addr + 4'h1;
          end
        end
      end
      sult_pkg::ST_READ: begin
        next_rd = 1'b1;
        next_wr = !i_manual_step;
        if (i_ground_air) begin
          next_osr = i_dual_channel ? 2'h3 : 2'h1;
        end
        // Readout may begin mid-frame; a partial word would be a false
        // error, so collection only starts at the next frame boundary.
        if (i_bit_count == `SULT_FRAME_START) begin
          next_armed = 1'b1;
        end
        // Each step shifts one bit in; the G/A step skips sync.
        if (armed && i_shift_timing_pulse &&
            !(i_ground_air && i_sync)) begin
          next_tsr = {tsr[WORD_BITS-2:0], bit_in};
        end
        if (i_bit_count_error) begin
          next_err = 1'b1;
        end
        if (i_phase_toggle_pulse && last_count) begin
          next_phase = !phase;
        end
        if (armed && xfer_pulse) begin
          next_xfer = 1'b1;
        end
        if (xfer) begin
          // Complementing means a good word leaves all zeros.
          next_obr = ret_word;
          next_armed = 1'b0;
          next_par = i_ground_air && i_parity_switch;
          next_state = sult_pkg::ST_CHECK;
          next_zchk = 1'b0;
        end
      end
      sult_pkg::ST_CHECK: begin
        if (par && i_parity_set_timing_pulse) begin
          next_obr[`SULT_PARITY_BIT] = 1'b1;
        end else if (par) begin
          next_par = 1'b1;
        end
        if (!par && (!i_ground_air || i_zero_test_timing_pulse)) begin
          next_zchk = 1'b1;
          if (obr != '0) begin
            next_err = 1'b1;
          end
          if (obr != '0 && i_halt_on_error) begin
            next_state = sult_pkg::ST_HALT;
          end else begin
            next_obr = i_test_word;
            next_addr = i_manual_step ? addr + 4'h1 : 4'h0;
            if (i_manual_step && addr == NUM_ADDRS - 4'h1) begin
              next_addr = 4'h0;
            end
            next_state = sult_pkg::ST_FILL;
          end
        end
      end
      sult_pkg::ST_HALT: begin
      end
      default: next_state = sult_pkg::ST_IDLE;
    endcase
    if (i_end_test || !i_unit_test) begin
      next_state = sult_pkg::ST_IDLE;
      next_slots = 1'b0;
    end
    if (i_manual_step) begin
      next_slots = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= sult_pkg::ST_IDLE;
      tsr <= '0;
      obr <= '0;
      addr <= 4'h0;
      phase <= 1'b0;
      slots <= 1'b0;
      err <= 1'b0;
      xfer <= 1'b0;
      zchk <= 1'b0;
      par <= 1'b0;
      output_shift_register <= 2'h0;
      wr <= 1'b0;
      rd <= 1'b0;
      armed <= 1'b0;
    end else begin
      armed <= next_armed;
      state <= next_state;
      tsr <= next_tsr;
      obr <= next_obr;
      addr <= next_addr;
      phase <= next_phase;
      slots <= next_slots;
      err <= next_err;
      xfer <= next_xfer;
      zchk <= next_zchk;
      par <= next_par;
      output_shift_register <= next_osr;
      wr <= next_wr;
      rd <= next_rd;
    end
  end

  // Status and isolation outputs, all registered.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_isolate_drum <= 1'b0;
      o_inhibit_burst <= 1'b0;
      o_clear_alarms <= 1'b0;
      o_inhibit_right_reset <= 1'b0;
      o_active <= 1'b0;
      o_halted <= 1'b0;
    end else begin
      o_isolate_drum <= i_unit_test;
      o_inhibit_burst <= i_unit_test;
      o_clear_alarms <= i_unit_test &&
                        next_state == sult_pkg::ST_IDLE;
      o_inhibit_right_reset <= i_unit_test;
      o_active <= next_state != sult_pkg::ST_IDLE;
      o_halted <= next_state == sult_pkg::ST_HALT;
    end
  end

  assign o_write_en = wr;
  assign o_write_addr = addr;
  assign o_read_en = rd;
  assign o_phase = phase;
  assign o_message_slot_register = slots;
  assign o_osr_load = output_shift_register;
  assign o_output_buffer_register = obr;
  assign o_error = err;
endmodule // sult_loop_test

// file: verilog/sult_params.svh
`ifndef SULT_PARAMS_SVH
`define SULT_PARAMS_SVH
`define SULT_WORD_BITS 17
`define SULT_GG_LAST_COUNT 5'h12
`define SULT_GA_LAST_COUNT 5'h0F
`define SULT_GA_XFER_COUNT 5'h11
`define SULT_GA_COLUMNS 4'hC
`define SULT_GG_ADDRS 4'hC
`define SULT_PARITY_BIT 0
`define SULT_FRAME_START 5'h00
`endif

// file: verilog/sult_pkg.sv
package sult_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_FILL = 5'h02,
    ST_READ = 5'h04,
    ST_CHECK = 5'h08,
    ST_HALT = 5'h10
  } sult_state_t;
endpackage

// file: test/sult_far_model.sv
module sult_far_model (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Scenario controls.
  input wire logic i_ga,
  input wire logic i_bad,
  input wire logic [16:0] i_word,
  // Timing and serial data toward the block.
  output logic o_shift,
  output logic o_toggle,
  output logic o_zero,
  output logic [4:0] o_count,
  output logic o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_count <= 5'h00;
    end else begin
      o_count <= (o_count == 5'h12) ? 5'h00 : o_count + 5'h01;
    end
  end
  assign o_shift = (o_count != 5'h00) && (o_count < 5'h12);
  assign o_toggle = o_count == (i_ga ? 5'h0F : 5'h12);
  assign o_zero = o_count == 5'h00;
  // Off the shift slots the line shows a changed level, not a stale bit.
  assign o_data = o_shift ?
    i_word[5'h11 - o_count] ^ (i_bad && o_count == 5'h11) : ~i_word[0];
endmodule // sult_far_model

// file: test/sult_loop_chk.sv
module sult_loop_chk #(
  parameter logic [3:0] NUM_ADDRS = 4'hC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_unit_test,
  input wire logic i_end_test,
  input wire logic i_ground_air,
  input wire logic i_manual_step,
  input wire logic i_halt_on_error,
  input wire logic i_phase_toggle_pulse,
  input wire logic [4:0] i_bit_count,
  input wire logic i_bit_count_error,
  input wire logic o_isolate_drum,
  input wire logic o_write_en,
  input wire logic [3:0] o_write_addr,
  input wire logic o_read_en,
  input wire logic o_phase,
  input wire logic o_message_slot_register,
  input wire logic o_error,
  input wire logic o_halted,
  input wire logic o_active
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence toggle_slot;
    o_read_en && i_phase_toggle_pulse &&
      i_bit_count == (i_ground_air ? 5'h0F : 5'h12);
  endsequence
  a_isolate_follows: assert property (
    $past(i_rst_b) |-> o_isolate_drum == $past(i_unit_test))
    else $error("isolate level wrong");
  a_phase_flips: assert property (
    toggle_slot |=> o_phase != $past(o_phase)) else $error("phase stuck");
  a_addr_legal: assert property (
    o_write_en |-> o_write_addr < NUM_ADDRS) else $error("bad address");
  a_slot_manual: assert property (
    i_manual_step [*2] |-> !o_message_slot_register)
    else $error("slot set in manual");
  a_count_error: assert property (
    o_read_en && i_bit_count_error |=> o_error) else $error("no error");
  a_halt_cause: assert property (
    $rose(o_halted) |-> o_error && $past(i_halt_on_error))
    else $error("halt without cause");
  a_halt_stays: assert property (
    o_halted && i_unit_test && !i_end_test |=> o_halted)
    else $error("halt released");
  a_start_phase: assert property (
    $rose(o_active) |-> !o_phase) else $error("phase not cleared");
endmodule // sult_loop_chk
bind sult_loop_test sult_loop_chk #(.NUM_ADDRS(NUM_ADDRS)) chk (.*);

// file: test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic ut = 1'b0, st = 1'b0, et = 1'b0, ga = 1'b0, dual = 1'b0;
  logic ch2 = 1'b0, hoe = 1'b0, bad = 1'b0, bce = 1'b0, man = 1'b0;
  logic ca, msr;
  logic [1:0] output_shift_register;
  logic [16:0] ob;
  logic [16:0] word = 17'h00000;
  logic sh, tg, zr, dt, iso, inh, we, re, err, hlt, act;
  logic [4:0] cnt;
  logic [31:0] r;
  integer seed = 32'h99f0, error_cnt = 0, num_checks = 0, n, i, fills;
  always #50 i_sys_clk = ~i_sys_clk;
  sult_far_model far (.i_sys_clk, .i_rst_b, .i_ga(ga), .i_bad(bad),
    .i_word(word), .o_shift(sh), .o_toggle(tg), .o_zero(zr),
    .o_count(cnt), .o_data(dt));
  sult_loop_test uut (.i_sys_clk, .i_rst_b, .i_unit_test(ut),
    .i_start_cycle(st), .i_end_test(et), .i_ground_air(ga),
    .i_manual_step(man), .i_step(man), .i_dual_channel(dual),
    .i_chan2_select(ch2), .i_halt_on_error(hoe), .i_parity_switch(1'b0),
    .i_test_word(word), .i_shift_timing_pulse(sh), .i_sync(1'b0),
    .i_phase_toggle_pulse(tg), .i_zero_test_timing_pulse(zr),
    .i_parity_set_timing_pulse(1'b0), .i_bit_count(cnt), .i_test_data(dt),
    .i_test_data_ch2(dt), .i_bit_count_error(bce), .o_isolate_drum(iso),
    .o_inhibit_burst(inh), .o_clear_alarms(ca), .o_inhibit_right_reset(),
    .o_write_en(we), .o_write_addr(), .o_read_en(re), .o_phase(),
    .o_message_slot_register(msr), .o_osr_load(output_shift_register),
    .o_output_buffer_register(ob), .o_error(err), .o_halted(hlt),
    .o_active(act));
  function automatic logic [4:0] exp_err(input logic b, input logic c);
    return {4'h0, b | c};
  endfunction
  task chk(input string nm, input logic [4:0] e, input logic [4:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task final_report;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Every wait is bounded so a stuck sequencer ends the run cleanly.
  task wait_on(input int k);
    for (i = 0; i < 400; i++) begin
      @(posedge i_sys_clk);
      st <= 1'b0;
      #1;
      if (k == 0 && we === 1'b1 && re !== 1'b1) fills++;
      if (k == 0 && re === 1'b1) return;
      if (k == 1 && re === 1'b0) return;
      if (k == 2 && (hlt === 1'b1 || we === 1'b1)) return;
    end
    chk("wait", 5'h00, 5'h01);
    final_report();
  endtask
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    ut <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk("isolate", 5'h07, {2'h0, ca, iso, inh});
    for (n = 0; n < 6; n++) begin
      @(posedge i_sys_clk);
      r = $random(seed);
      word <= r[16:0];
      ga <= r[17];
      dual <= r[18];
      ch2 <= r[18] & r[19];
      hoe <= r[20] | (n == 5);
      bad <= r[21] | (n == 5);
      bce <= r[21] & r[22];
      man <= (n == 3);
      st <= 1'b1;
      fills = 0;
      wait_on(0);
      chk("fills", man ? 5'h01 : 5'h0C, fills[4:0]);
      chk("slots", {4'h0, ~man}, {4'h0, msr});
      chk("osr", {3'h0, ga & dual, ga}, {3'h0, output_shift_register});
      wait_on(1);
      wait_on(2);
      chk("error", exp_err(bad, bce), {4'h0, err});
      chk("halt", exp_err(bad, bce) & {4'h0, hoe}, {4'h0, hlt});
      chk("buffer", (hoe & bad) ? 5'h01 : word[4:0], ob[4:0]);
      @(posedge i_sys_clk);
      et <= 1'b1;
      @(posedge i_sys_clk);
      et <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      #1;
      chk("active", 5'h00, {4'h0, act});
    end
    final_report();
  end
endmodule // testbench
